/* logic/rcl_pkg.sv */
// shared constants, types and helpers of the rtc control logic
// assumes a 125 MHz system clock and a 2048 Hz time-base tick from the crystal divider
package rcl_pkg;

  // register addresses on the serial link
  localparam logic [3:0] ADDR_IRQ_SEL = 4'h7;
  localparam logic [3:0] ADDR_CTRL    = 4'he;
  localparam logic [3:0] ADDR_TEST    = 4'hf;
  localparam logic [3:0] READ_ZERO    = 4'h0;

  // field positions
  localparam int CTRL_FLAG_BIT = 3;
  localparam int CTRL_FMT_BIT  = 2;
  localparam int CTRL_GATE_BIT = 1;
  localparam int CTRL_ADJ_BIT  = 0;
  localparam int TEST_BIT      = 0;
  localparam int SEL_MODE_BIT  = 3;

  // reset values
  localparam logic [3:0] IRQ_SEL_RST = 4'h0;
  localparam logic       GATE_RST    = 1'b1;
  localparam logic       FMT24_RST   = 1'b0;
  localparam logic       OSC_HALT_RST = 1'b1;
  localparam logic       TEST_RST    = 1'b1;

  // timing
  localparam real SYS_MHZ     = 125.0;
  localparam real BUSY_MAX_US = 122.1;
  localparam int  BUSY_CYC    = int'($floor(BUSY_MAX_US * SYS_MHZ));
  localparam int  BUSY_W      = 14;
  localparam int  PRE_W       = 11;
  localparam logic [PRE_W-1:0] PRE_LAST = 11'h7ff;
  localparam int  PRE_HALF_BIT = 9;

  // synchroniser lanes on the system side
  localparam int SY_W   = 4;
  localparam int SY_CE  = 3;
  localparam int SY_OSC = 2;
  localparam int SY_WR  = 1;
  localparam int SY_RD  = 0;

  // serial frame: positions in the shift register when the last bit arrives
  localparam int CMD_RW_POS = 5;
  localparam int CMD_AD_POS = 4;
  localparam int CMD_DT_POS = 3;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_OE_FIRST   = 3'h1;
  localparam logic [2:0] BIT_DATA_FIRST = 3'h4;

  // counter values that mark rollovers
  localparam logic [7:0] SEC_ZERO   = 8'h00;
  localparam logic [7:0] MIN_ZERO   = 8'h00;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [2:0] WDAY_FIRST = 3'h0;
  localparam logic [7:0] DAY_FIRST  = 8'h01;
  localparam logic [4:0] HOUR_ZERO  = 5'h00;
  localparam logic [4:0] HOUR_NOON  = 5'h0c;
  localparam logic [4:0] HOUR_TEN   = 5'h0a;
  localparam logic [4:0] HOUR_TWENTY = 5'h14;
  localparam int         PM_BIT     = 5;

  typedef enum logic [1:0] {
    PM_OFF  = 2'b00,
    PM_LOW  = 2'b01,
    PM_FAST = 2'b10,
    PM_HALF = 2'b11
  } rcl_pulse_e;

  typedef enum logic [2:0] {
    LV_SEC   = 3'b000,
    LV_10S   = 3'b001,
    LV_MIN   = 3'b010,
    LV_10M   = 3'b011,
    LV_HOUR  = 3'b100,
    LV_DAY   = 3'b101,
    LV_WEEK  = 3'b110,
    LV_MONTH = 3'b111
  } rcl_level_e;

  typedef enum logic {
    BY_CMD  = 1'b0,
    BY_READ = 1'b1
  } rcl_byte_e;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] day;
  } rcl_time_s;

  typedef struct packed {
    logic       wrToggle;
    logic [3:0] wrAddr;
    logic [3:0] wrData;
    logic       rdToggle;
    logic [3:0] rdAddr;
  } rcl_link_req_s;

  // binary hour 0..23 to the bcd hour register form
  function automatic logic [7:0] hourEncode(input logic [4:0] h, input logic fmt24);
    logic [4:0] v;
    logic [7:0] bcd;
    v = h;
    if (!fmt24)
    begin
      if (h >= HOUR_NOON) v = h - HOUR_NOON;
      if (v == HOUR_ZERO) v = HOUR_NOON;
    end
    if (v >= HOUR_TWENTY) bcd = {4'h2, 4'(v - HOUR_TWENTY)};
    else if (v >= HOUR_TEN) bcd = {4'h1, 4'(v - HOUR_TEN)};
    else bcd = {4'h0, 4'(v)};
    if (!fmt24 && h >= HOUR_NOON) bcd[PM_BIT] = 1'b1;
    return bcd;
  endfunction

endpackage

/* logic/rcl_sync.sv */
// three-stage synchroniser; a change passes once stages two and three agree
// assumes a synchronous active-low reset in the destination domain
`timescale 1ns/1ps
`default_nettype none
module rcl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } rcl_sync_s;

  rcl_sync_s st_q;
  rcl_sync_s st_d;

  always_comb
  begin
    st_d     = st_q;
    st_d.s1  = d;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.out = (st_q.s3 & ~(st_q.s2 ^ st_q.s3)) | (st_q.out & (st_q.s2 ^ st_q.s3));
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n) st_q <= '0;
    else st_q <= st_d;
  end

  assign q = st_q.out;
endmodule // rcl_sync
`default_nettype wire

/* logic/rcl_serial_link.sv */
// three-wire serial slave on the shift clock: decodes address, write and read bytes
// assumes read data is held stable by the system side from well before data bit one
`timescale 1ns/1ps
`default_nettype none
module rcl_serial_link (
  input  wire logic                  sclk,
  input  wire logic                  reset_n,
  input  wire logic                  ceIn,
  input  wire logic                  sioI,
  output logic                       sioO,
  output logic                       sioOeN,
  input  wire logic [3:0]            rdData,
  output rcl_pkg::rcl_link_req_s     req
);
  typedef struct packed {
    logic [2:0]         bitCnt;
    logic [6:0]         shift;
    rcl_pkg::rcl_byte_e kind;
  } rcl_frame_s;

  typedef struct packed {
    rcl_pkg::rcl_link_req_s req;
    logic [3:0]             addr;
  } rcl_rec_s;

  rcl_frame_s frm_q;
  rcl_frame_s frm_d;
  rcl_rec_s   rec_q;
  rcl_rec_s   rec_d;
  logic       outO_q;
  logic       outOeN_q;
  logic [3:0] nib;
  logic       lastBit;

  assign nib     = {frm_q.shift[2:0], sioI};
  assign lastBit = (frm_q.bitCnt == rcl_pkg::BIT_LAST) && (frm_q.kind == rcl_pkg::BY_CMD);

  always_comb
  begin
    frm_d        = frm_q;
    frm_d.bitCnt = frm_q.bitCnt + 3'h1;
    frm_d.shift  = {frm_q.shift[5:0], sioI};
    if (frm_q.bitCnt == rcl_pkg::BIT_LAST)
    begin
      frm_d.kind = rcl_pkg::BY_CMD;
      if (lastBit && frm_q.shift[rcl_pkg::CMD_RW_POS] && frm_q.shift[rcl_pkg::CMD_AD_POS]
          && !frm_q.shift[rcl_pkg::CMD_DT_POS])
        frm_d.kind = rcl_pkg::BY_READ;
    end
  end

  always_comb
  begin
    rec_d = rec_q;
    if (lastBit && frm_q.shift[rcl_pkg::CMD_AD_POS] && !frm_q.shift[rcl_pkg::CMD_DT_POS])
    begin
      rec_d.addr = nib;
      if (frm_q.shift[rcl_pkg::CMD_RW_POS])
      begin
        rec_d.req.rdAddr   = nib;
        rec_d.req.rdToggle = ~rec_q.req.rdToggle;
      end
    end
    if (lastBit && frm_q.shift[rcl_pkg::CMD_DT_POS] && !frm_q.shift[rcl_pkg::CMD_AD_POS]
        && !frm_q.shift[rcl_pkg::CMD_RW_POS])
    begin
      rec_d.req.wrAddr   = rec_q.addr;
      rec_d.req.wrData   = nib;
      rec_d.req.wrToggle = ~rec_q.req.wrToggle;
    end
  end

  // frame position restarts whenever chip enable is low
  always_ff @(negedge sclk or negedge ceIn)
  begin
    if (!ceIn) frm_q <= '0;
    else frm_q <= frm_d;
  end

  always_ff @(negedge sclk or negedge reset_n)
  begin
    if (!reset_n) rec_q <= '0;
    else rec_q <= rec_d;
  end

  // drive from rising edge 2 of a read byte, data bits on rising edges 5..8
  always_ff @(posedge sclk or negedge ceIn)
  begin
    if (!ceIn)
    begin
      outO_q   <= 1'b0;
      outOeN_q <= 1'b1;
    end
    else
    begin
      outOeN_q <= !((frm_q.kind == rcl_pkg::BY_READ) && (frm_q.bitCnt >= rcl_pkg::BIT_OE_FIRST));
      if ((frm_q.kind == rcl_pkg::BY_READ) && (frm_q.bitCnt >= rcl_pkg::BIT_DATA_FIRST))
        outO_q <= rdData[2'(rcl_pkg::BIT_LAST - frm_q.bitCnt)];
      else
        outO_q <= 1'b0;
    end
  end

  assign sioO   = outO_q;
  assign sioOeN = outOeN_q;
  assign req    = rec_q.req;
endmodule // rcl_serial_link
`default_nettype wire

/* logic/rcl_rtc_ctrl.sv */
// control, status and interrupt logic of a serial real-time clock
// assumes an external counter chain that applies seconds increments and adjusts,
// a 2048 Hz tick from the crystal divider, and a host on the three-wire link
//
// Functional notes
// - busy flag reads 1 while counters update, else 0.
// - host sets carry gate again; chip enable low forces it to 1.
// - carry arriving while gate is 0 is applied when gate returns to 1.
// - with chip enable low, a crystal stop sets the halt flag; it stays set.
// - with chip enable high, halt flag changes only by a control write; detector ignored.
// - a control register write during normal oscillation clears the halt flag.
// - 12-hour hours: midnight 12, noon 32, afternoon 21-31; 24-hour 00-23.
// - interrupt flag is 1 whenever an interrupt event pulls the output low.
// - flag writes act only in level mode; 1 pulls output low, 0 releases.
// - pulse mode codes: off, held low, 0.977 ms square, 0.5 s period.
// - level mode codes select second through month intervals.
// - level events fire on counter rollovers at the documented boundaries.
// - 4-bit readable writable interrupt selector at address 7h.
// - write-only active-low test bit at Fh; reads return 0000.
// - test bit stays 1 normally and is forced to 1 while chip enable low.
// - control bit 1 is gate or halt flag, bit 0 adjust or busy.
// - busy after an adjust lasts no longer than 122.1 us.
`timescale 1ns/1ps
`default_nettype none
module rcl_rtc_ctrl #(
  parameter logic [rcl_pkg::BUSY_W-1:0] BusyCycles = rcl_pkg::BUSY_W'(rcl_pkg::BUSY_CYC)
) (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                sclk,
  input  wire logic                ceIn,
  input  wire logic                sioI,
  output logic                     sioO,
  output logic                     sioOeN,
  input  wire logic                oscStopIn,
  input  wire logic                tick2048,
  input  wire logic                secUpdated,
  input  wire rcl_pkg::rcl_time_s  curTime,
  output logic                     secIncrement,
  output logic                     adjustReq,
  output logic                     hourFmt24,
  output logic                     testNormal,
  output logic                     irqOutO,
  output logic                     irqOutOeN
);
  typedef struct packed {
    logic [3:0]                  irqSel;
    logic                        gate;
    logic                        carryPend;
    logic                        adjPend;
    logic                        fmt24;
    logic                        irqFlag;
    logic                        oscHalt;
    logic                        testBit;
    logic [rcl_pkg::BUSY_W-1:0]  busyCnt;
    logic [rcl_pkg::PRE_W-1:0]   pre;
    logic                        wrSeen;
    logic                        rdSeen;
    logic [3:0]                  rdData;
    logic                        secInc;
    logic                        adjReq;
    logic                        irqOeN;
  } rcl_core_s;

  rcl_core_s                     st_q;
  rcl_core_s                     st_d;
  rcl_pkg::rcl_link_req_s        linkReq;
  logic [rcl_pkg::SY_W-1:0]      syncQ;

  rcl_serial_link u_link (
    .sclk    (sclk),
    .reset_n (reset_n),
    .ceIn    (ceIn),
    .sioI    (sioI),
    .sioO    (sioO),
    .sioOeN  (sioOeN),
    .rdData  (st_q.rdData),
    .req     (linkReq)
  );

  rcl_sync #(
    .W (rcl_pkg::SY_W)
  ) u_sync (
    .clk     (sys_clk),
    .reset_n (reset_n),
    .d       ({ceIn, oscStopIn, linkReq.wrToggle, linkReq.rdToggle}),
    .q       (syncQ)
  );

  always_comb
  begin
    logic ceLow;
    logic oscStop;
    logic wrEv;
    logic rdEv;
    logic secCarry;
    logic secZ;
    logic minZ;
    logic midnight;
    logic lvEv;
    logic drive;
    logic [3:0] wd;
    ceLow    = !syncQ[rcl_pkg::SY_CE];
    oscStop  = syncQ[rcl_pkg::SY_OSC];
    wrEv     = syncQ[rcl_pkg::SY_WR] != st_q.wrSeen;
    rdEv     = syncQ[rcl_pkg::SY_RD] != st_q.rdSeen;
    secCarry = tick2048 && (st_q.pre == rcl_pkg::PRE_LAST);
    secZ     = curTime.sec == rcl_pkg::SEC_ZERO;
    minZ     = curTime.min == rcl_pkg::MIN_ZERO;
    midnight = curTime.hour == rcl_pkg::hourEncode(rcl_pkg::HOUR_ZERO, st_q.fmt24);
    lvEv     = 1'b0;
    drive    = 1'b0;
    wd       = linkReq.wrData;

    st_d        = st_q;
    st_d.wrSeen = syncQ[rcl_pkg::SY_WR];
    st_d.rdSeen = syncQ[rcl_pkg::SY_RD];
    if (tick2048) st_d.pre = st_q.pre + 11'h001;

    // carry gate: deferred carry is one pending bit
    st_d.secInc    = st_q.gate && (secCarry || st_q.carryPend);
    st_d.carryPend = (secCarry && (!st_q.gate || st_q.carryPend))
                     || (st_q.carryPend && !st_q.gate);
    st_d.adjReq    = st_q.gate && st_q.adjPend;
    if (st_d.adjReq) st_d.adjPend = 1'b0;

    // busy covers each increment or adjust, bounded by BusyCycles
    if (st_d.secInc || st_d.adjReq) st_d.busyCnt = BusyCycles;
    else if (st_q.busyCnt != '0) st_d.busyCnt = st_q.busyCnt - 14'h0001;

    if (wrEv)
    begin
      case (linkReq.wrAddr)
        rcl_pkg::ADDR_IRQ_SEL: st_d.irqSel = wd;
        rcl_pkg::ADDR_CTRL:
        begin
          st_d.gate  = wd[rcl_pkg::CTRL_GATE_BIT];
          st_d.fmt24 = wd[rcl_pkg::CTRL_FMT_BIT];
          if (wd[rcl_pkg::CTRL_ADJ_BIT]) st_d.adjPend = 1'b1;
          if (st_q.irqSel[rcl_pkg::SEL_MODE_BIT]) st_d.irqFlag = wd[rcl_pkg::CTRL_FLAG_BIT];
          if (!oscStop) st_d.oscHalt = 1'b0;
        end
        rcl_pkg::ADDR_TEST: st_d.testBit = wd[rcl_pkg::TEST_BIT];
        default: ;
      endcase
    end

    if (ceLow)
    begin
      st_d.gate    = 1'b1;
      st_d.testBit = 1'b1;
      if (oscStop) st_d.oscHalt = 1'b1;
    end
    // with chip enable high the halt flag only changes by a control write

    // level-mode rollover events
    unique case (rcl_pkg::rcl_level_e'(st_q.irqSel[2:0]))
      rcl_pkg::LV_SEC:   lvEv = 1'b1;
      rcl_pkg::LV_10S:   lvEv = curTime.sec[3:0] == rcl_pkg::DIGIT_ZERO;
      rcl_pkg::LV_MIN:   lvEv = secZ;
      rcl_pkg::LV_10M:   lvEv = secZ && (curTime.min[3:0] == rcl_pkg::DIGIT_ZERO);
      rcl_pkg::LV_HOUR:  lvEv = secZ && minZ;
      rcl_pkg::LV_DAY:   lvEv = secZ && minZ && midnight;
      rcl_pkg::LV_WEEK:  lvEv = secZ && minZ && midnight && (curTime.wday == rcl_pkg::WDAY_FIRST);
      rcl_pkg::LV_MONTH: lvEv = secZ && minZ && midnight && (curTime.day == rcl_pkg::DAY_FIRST);
    endcase

    if (st_q.irqSel[rcl_pkg::SEL_MODE_BIT])
    begin
      if (secUpdated && lvEv) st_d.irqFlag = 1'b1;
      drive = st_d.irqFlag;
    end
    else
    begin
      unique case (rcl_pkg::rcl_pulse_e'(st_q.irqSel[1:0]))
        rcl_pkg::PM_OFF:  drive = 1'b0;
        rcl_pkg::PM_LOW:  drive = 1'b1;
        rcl_pkg::PM_FAST: drive = st_q.pre[0];
        rcl_pkg::PM_HALF: drive = st_q.pre[rcl_pkg::PRE_HALF_BIT];
      endcase
      st_d.irqFlag = drive;
    end
    st_d.irqOeN = !drive;

    if (rdEv)
    begin
      case (linkReq.rdAddr)
        rcl_pkg::ADDR_IRQ_SEL: st_d.rdData = st_q.irqSel;
        rcl_pkg::ADDR_CTRL:
          st_d.rdData = {st_q.irqFlag, st_q.fmt24, st_q.oscHalt, st_q.busyCnt != '0};
        default: st_d.rdData = rcl_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_q         <= '0;
      st_q.irqSel  <= rcl_pkg::IRQ_SEL_RST;
      st_q.gate    <= rcl_pkg::GATE_RST;
      st_q.fmt24   <= rcl_pkg::FMT24_RST;
      st_q.oscHalt <= rcl_pkg::OSC_HALT_RST;
      st_q.testBit <= rcl_pkg::TEST_RST;
      st_q.irqOeN  <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign secIncrement = st_q.secInc;
  assign adjustReq    = st_q.adjReq;
  assign hourFmt24    = st_q.fmt24;
  assign testNormal   = st_q.testBit;
  // open-drain pin only ever pulls low
  assign irqOutO      = 1'b0;
  assign irqOutOeN    = st_q.irqOeN;
endmodule // rcl_rtc_ctrl
`default_nettype wire

/* dv/rcl_rtc_ctrl_monitor.sv */
// port checker of the rtc control block
// assumes binding to rcl_rtc_ctrl; link pins are sampled on sys_clk
`timescale 1ns/1ps
`default_nettype none
module rcl_rtc_ctrl_monitor #(
  parameter logic [rcl_pkg::BUSY_W-1:0] BusyCycles = 14'h0014
) (
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic               sclk,
  input wire logic               ceIn,
  input wire logic               sioI,
  input wire logic               sioO,
  input wire logic               sioOeN,
  input wire logic               oscStopIn,
  input wire logic               tick2048,
  input wire logic               secUpdated,
  input wire rcl_pkg::rcl_time_s curTime,
  input wire logic               secIncrement,
  input wire logic               adjustReq,
  input wire logic               hourFmt24,
  input wire logic               testNormal,
  input wire logic               irqOutO,
  input wire logic               irqOutOeN
);
  // cycles since chip enable went low; host writes land only near a frame
  logic [5:0] ceLowQ;
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || ceIn)
      ceLowQ <= 6'h00;
    else if (ceLowQ != 6'h3f)
      ceLowQ <= ceLowQ + 6'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_RESET_STATE: assert property ($rose(reset_n) |-> testNormal && irqOutOeN)
    else $error("outputs not at reset state");
  AST_IRQ_DATA_LOW: assert property (irqOutO == 1'b0)
    else $error("interrupt data not low");
  AST_ADJ_ONE_CYCLE: assert property (adjustReq |=> !adjustReq)
    else $error("adjust request longer than one cycle");
  AST_TEST_FORCED: assert property (!testNormal |-> ceLowQ < 6'h08)
    else $error("test bit low with chip enable low");
  AST_FMT_BY_HOST: assert property ($changed(hourFmt24) |-> ceLowQ < 6'h0a)
    else $error("hour format changed outside a frame");
  AST_ADJ_GATED: assert property ($rose(adjustReq) |-> ceLowQ < 6'h0c)
    else $error("adjust issued without host action");
  AST_INC_CAUSE: assert property (secIncrement |->
      $past(tick2048) || $past(tick2048, 2) || ceLowQ < 6'h0c)
    else $error("seconds increment without carry or gate release");
  AST_IRQ_CAUSE: assert property ($changed(irqOutOeN) |-> $past(tick2048) ||
      $past(tick2048, 2) || $past(secUpdated) || ceLowQ < 6'h0c)
    else $error("interrupt pin moved without cause");
  AST_SIO_RELEASED: assert property (!ceIn |-> sioOeN)
    else $error("data pin driven outside a frame");
  AST_SIO_IDLE_LOW: assert property (sioOeN |-> !sioO)
    else $error("data out not low while released");
  COV_INC: cover property (secIncrement ##1 !secIncrement);
  COV_ADJ: cover property (adjustReq);
  COV_IRQ: cover property ($fell(irqOutOeN));
endmodule // rcl_rtc_ctrl_monitor
`default_nettype wire

/* dv/rcl_host_model.sv */
// host model driving the three-wire link of the rtc control block
// assumes sclk idles low outside frames, device shifts in on falling and out on rising;
// the device owns sio while sioOeN is low
`timescale 1ns/1ps
`default_nettype none
module rcl_host_model (
  output logic      sclk,
  output logic      ceIn,
  output logic      sioI,
  input  wire logic sioO,
  input  wire logic sioOeN
);
  logic       hostBit;
  logic [7:0] junk;
  assign sioI = sioOeN ? hostBit : sioO;
  initial
  begin
    sclk = 1'b0;
    ceIn = 1'b1;
    hostBit = 1'b0;
    // clean falling edge so the link frame position starts known
    #1 ceIn = 1'b0;
  end
  task automatic shiftByte(input logic [7:0] b, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      hostBit = b[i];
      #14 sclk = 1'b1;
      #14 v[i] = sioI;
      #1 sclk = 1'b0;
      #1;
    end
  endtask
  task automatic openFrame();
    ceIn = 1'b1;
    #40;
  endtask
  // short frames keep the carry gate closed well under a millisecond
  task automatic closeFrame();
    #30 ceIn = 1'b0;
    hostBit = ~hostBit;
    #60;
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [3:0] w);
    shiftByte({4'h2, a}, junk);
    shiftByte({4'h1, w}, junk);
  endtask
  task automatic rdReg(input logic [3:0] a, output logic [3:0] r);
    shiftByte({4'h6, a}, junk);
    shiftByte(8'h55, junk);
    r = junk[3:0];
  endtask
endmodule // rcl_host_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench of the rtc control block
// assumes the host model owns the link; the bench drives the time-base side
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
  localparam logic [13:0] BusyCycles = 14'h00c8;
  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic [3:0] rdExp;
    logic       irqExp;
    logic       tnExp;
  } rcl_row_s;
  rcl_row_s           rows [6];
  logic               sys_clk;
  logic               reset_n;
  logic               sclk;
  logic               ceIn;
  logic               sioI;
  logic               sioO;
  logic               sioOeN;
  logic               oscStopIn;
  logic               tick2048;
  logic               secUpdated;
  rcl_pkg::rcl_time_s curTime;
  rcl_pkg::rcl_time_s base;
  rcl_pkg::rcl_time_s t;
  logic               secIncrement;
  logic               adjustReq;
  logic               hourFmt24;
  logic               testNormal;
  logic               irqOutO;
  logic               irqOutOeN;
  logic               irqPrev;
  logic [3:0]         d;
  int                 miscompares;
  int                 testsRun;
  int                 incPulses;
  int                 adjPulses;
  int                 irqEdges;
  int                 cycles;
  int                 n;
  rcl_rtc_ctrl #(.BusyCycles(BusyCycles)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .ceIn(ceIn), .sioI(sioI),
    .sioO(sioO), .sioOeN(sioOeN), .oscStopIn(oscStopIn), .tick2048(tick2048),
    .secUpdated(secUpdated), .curTime(curTime), .secIncrement(secIncrement),
    .adjustReq(adjustReq), .hourFmt24(hourFmt24), .testNormal(testNormal),
    .irqOutO(irqOutO), .irqOutOeN(irqOutOeN));
  rcl_host_model host (.sclk(sclk), .ceIn(ceIn), .sioI(sioI), .sioO(sioO), .sioOeN(sioOeN));
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    incPulses += int'(secIncrement === 1'b1);
    adjPulses += int'(adjustReq === 1'b1);
    irqEdges += int'(irqOutOeN !== irqPrev);
    irqPrev = irqOutOeN;
    if (cycles > 100000)
    begin
      miscompares++;
      finishTest();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic runTicks(input int k);
    repeat (k)
    begin
      step(1);
      tick2048 = 1'b1;
      step(1);
      tick2048 = 1'b0;
    end
  endtask
  task automatic pulseUpd(input rcl_pkg::rcl_time_s v);
    step(1);
    curTime = v;
    secUpdated = 1'b1;
    step(1);
    secUpdated = 1'b0;
    step(2);
  endtask
  task automatic readCtrl();
    host.openFrame();
    host.rdReg(4'he, d);
    host.closeFrame();
  endtask
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b1;
    oscStopIn = 1'b0;
    tick2048 = 1'b0;
    secUpdated = 1'b0;
    base = {8'h00, 8'h00, 8'h00, 3'h0, 8'h01};
    curTime = base;
    rows = '{'{4'h7, 4'h1, 4'h1, 1'b0, 1'b1}, '{4'h7, 4'h5, 4'h5, 1'b0, 1'b1},
             '{4'hf, 4'h0, 4'h0, 1'b0, 1'b0}, '{4'h3, 4'hf, 4'h0, 1'b0, 1'b1},
             '{4'h7, 4'h4, 4'h4, 1'b1, 1'b1}, '{4'h7, 4'h8, 4'h8, 1'b1, 1'b1}};
    // clean falling edge for the asynchronously reset link record
    #1 reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step(5);
    `CHK(testNormal, 1'b1)
    `CHK(irqOutOeN, 1'b1)
    readCtrl();
    `CHK(d, 4'h2)
    endTest("reset");
    foreach (rows[i])
    begin
      host.openFrame();
      host.wrReg(rows[i].addr, rows[i].wdata);
      host.rdReg(rows[i].addr, d);
      step(2);
      `CHK(d, rows[i].rdExp)
      `CHK(irqOutOeN, rows[i].irqExp)
      `CHK(testNormal, rows[i].tnExp)
      host.closeFrame();
    end
    endTest("table");
    runTicks(2047);
    `CHK(incPulses, 0)
    runTicks(1);
    step(2);
    `CHK(incPulses, 1)
    host.openFrame();
    host.rdReg(4'he, d);
    `CHK(d[0], 1'b1)
    host.wrReg(4'he, 4'h4);
    runTicks(2048);
    host.rdReg(4'he, d);
    `CHK(d[0], 1'b0)
    `CHK(incPulses, 1)
    host.closeFrame();
    step(12);
    `CHK(incPulses, 2)
    endTest("carry");
    host.openFrame();
    host.wrReg(4'he, 4'h7);
    host.rdReg(4'he, d);
    host.closeFrame();
    `CHK(adjPulses, 1)
    `CHK(d, 4'h5)
    step(210);
    readCtrl();
    `CHK(d, 4'h4)
    endTest("adjust");
    host.openFrame();
    step(5);
    oscStopIn = 1'b1;
    step(10);
    host.rdReg(4'he, d);
    `CHK(d[1], 1'b0)
    host.closeFrame();
    step(10);
    oscStopIn = 1'b0;
    step(10);
    host.openFrame();
    host.rdReg(4'he, d);
    `CHK(d[1], 1'b1)
    host.wrReg(4'he, 4'h6);
    host.rdReg(4'he, d);
    `CHK(d, 4'h4)
    host.closeFrame();
    `CHK(hourFmt24, 1'b1)
    endTest("halt");
    for (int c = 0; c < 8; c++)
    begin
      host.openFrame();
      host.wrReg(4'h7, 4'(8 + c));
      host.wrReg(4'he, 4'h6);
      host.closeFrame();
      t = base;
      case (c)
        1: t.sec = 8'h01;
        2: t.sec = 8'h10;
        3: t.min = 8'h01;
        4: t.min = 8'h10;
        5: t.hour = 8'h01;
        6: t.wday = 3'h1;
        7: t.day = 8'h02;
        default: t = base;
      endcase
      pulseUpd(t);
      `CHK(irqOutOeN, (c == 0) ? 1'b0 : 1'b1)
      pulseUpd(base);
      `CHK(irqOutOeN, 1'b0)
    end
    host.openFrame();
    host.rdReg(4'he, d);
    `CHK(d[3], 1'b1)
    host.wrReg(4'he, 4'h6);
    step(8);
    `CHK(irqOutOeN, 1'b1)
    host.wrReg(4'he, 4'he);
    step(8);
    `CHK(irqOutOeN, 1'b0)
    host.wrReg(4'h7, 4'hd);
    host.wrReg(4'he, 4'h2);
    host.closeFrame();
    t = base;
    t.hour = 8'h12;
    pulseUpd(t);
    `CHK(irqOutOeN, 1'b0)
    host.openFrame();
    host.wrReg(4'h7, 4'h0);
    host.wrReg(4'he, 4'he);
    step(8);
    `CHK(irqOutOeN, 1'b1)
    host.wrReg(4'h7, 4'h2);
    host.closeFrame();
    step(4);
    n = irqEdges;
    runTicks(8);
    step(3);
    `CHK(irqEdges - n, 8)
    host.openFrame();
    host.wrReg(4'h7, 4'h3);
    host.closeFrame();
    step(4);
    n = irqEdges;
    runTicks(1024);
    step(3);
    `CHK(irqEdges - n, 2)
    endTest("interrupt");
    finishTest();
  end
endmodule // testbench
bind rcl_rtc_ctrl rcl_rtc_ctrl_monitor #(.BusyCycles(BusyCycles)) mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .ceIn(ceIn), .sioI(sioI),
  .sioO(sioO), .sioOeN(sioOeN), .oscStopIn(oscStopIn), .tick2048(tick2048),
  .secUpdated(secUpdated), .curTime(curTime), .secIncrement(secIncrement),
  .adjustReq(adjustReq), .hourFmt24(hourFmt24), .testNormal(testNormal),
  .irqOutO(irqOutO), .irqOutOeN(irqOutOeN));
`default_nettype wire
